// ===== inc/eipu_regs.vh
// How it works
// - Pull device on while pin enabled, unless disable bit set.
// - Polarity bit picks falling/low or rising/high.
// - Rising selects pull-down, falling selects pull-up.
// - Pin enable gates all pin events.
// - Detected event sets read-only sticky flag.
// - Writing one to acknowledge clears flag.
// - Level mode: held level blocks acknowledge.
// - Interrupt enable forwards flag to CPU.
// - Mode bit: edges only, or edges plus levels.
`ifndef EIPU_REGS_VH
`define EIPU_REGS_VH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define EIPU_ADDR_W          12
`define EIPU_DATA_W          32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EIPU_OFF_CSR         12'h000
`define EIPU_OFF_STAT        12'h004
`define EIPU_OFF_MASK        12'h008

// ----------------------------------------------------------------------
// Status and control register fields
// ----------------------------------------------------------------------
`define EIPU_CSR_RSVD7       7
`define EIPU_CSR_PULL_DIS    6
`define EIPU_CSR_POLARITY    5
`define EIPU_CSR_PIN_EN      4
`define EIPU_CSR_FLAG        3
`define EIPU_CSR_ACK         2
`define EIPU_CSR_IRQ_EN      1
`define EIPU_CSR_MODE        0
`define EIPU_CSR_RESET       8'h00

// ----------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------
`define EIPU_EVT_W           2
`define EIPU_EVT_PIN         0
`define EIPU_EVT_ACK_HELD    1
`define EIPU_STAT_RESET      2'h0
`define EIPU_MASK_RESET      2'h0

// ----------------------------------------------------------------------
// Synchroniser
// ----------------------------------------------------------------------
`define EIPU_SYNC_RESET      1'b0

`endif

// ===== verilog/eipu_sync.v
`timescale 1ns/1ps
`include "eipu_regs.vh"

module eipu_sync (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Asynchronous level in, synchronous level out
   input  wire async_in,
   output wire sync_out
);

   reg meta_q;
   reg sync_q;

   // The first stage feeds only the second, so a metastable sample never
   // reaches any decision logic.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= `EIPU_SYNC_RESET;
         sync_q <= `EIPU_SYNC_RESET;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ===== verilog/eipu_top.v
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "eipu_regs.vh"

module eipu_top (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Interrupt request pin
   input  wire        irq_pin,
   // Pull device control
   output wire        pull_enable,
   output wire        pull_up_select,
   // Requests
   output wire        cpu_irq_req,
   output wire        irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg                     pull_dis_q;
   reg                     polarity_q;
   reg                     pin_en_q;
   reg                     flag_q;
   reg                     flag_d;
   reg                     irq_en_q;
   reg                     mode_q;
   reg  [`EIPU_EVT_W-1:0]  stat_q;
   reg  [`EIPU_EVT_W-1:0]  stat_d;
   reg  [`EIPU_EVT_W-1:0]  mask_q;
   reg  [31:0]             prdata_q;
   reg  [31:0]             prdata_d;
   reg                     pslverr_q;
   reg                     pslverr_d;
   reg                     prev_active_q;
   wire                    pin_sync;
   wire                    pin_active;
   wire                    edge_hit;
   wire                    level_hit;
   wire                    pin_event;
   wire                    setup_phase;
   wire                    wr_access;
   wire                    wr_csr;
   wire                    wr_stat;
   wire                    wr_mask;
   wire                    ack_req;
   wire                    ack_blocked;
   wire [`EIPU_EVT_W-1:0]  evt_set;
   wire [`EIPU_EVT_W-1:0]  evt_clr;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   // Word-aligned match; the two low address bits are ignored.
   function addr_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         addr_hit = (addr[11:2] == offset[11:2]);
      end
   endfunction

   // True when the address names one of the three registers.
   function addr_mapped;
      input [11:0] addr;
      begin
         addr_mapped = addr_hit(addr, `EIPU_OFF_CSR) |
                       addr_hit(addr, `EIPU_OFF_STAT) |
                       addr_hit(addr, `EIPU_OFF_MASK);
      end
   endfunction

   // Sticky update: a set in the same cycle as a clear wins.
   function [`EIPU_EVT_W-1:0] sticky_next;
      input [`EIPU_EVT_W-1:0] cur;
      input [`EIPU_EVT_W-1:0] set;
      input [`EIPU_EVT_W-1:0] clr;
      begin
         sticky_next = (cur & ~clr) | set;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchroniser and detection
   // ----------------------------------------------------------------------
   eipu_sync eipu_sync_inst (
      .clk      (clk),
      .rst      (rst),
      .async_in (irq_pin),
      .sync_out (pin_sync)
   );

   // Active means the level that the polarity bit selects.
   assign pin_active = polarity_q ? pin_sync : ~pin_sync;

   // The previous sample follows the pin even while disabled, so turning the
   // function on while the pin already sits active is not taken as an edge.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_active_q <= 1'b0;
      end else begin
         prev_active_q <= pin_active;
      end
   end

   assign edge_hit  = pin_active & ~prev_active_q;
   assign level_hit = mode_q & pin_active;
   assign pin_event = pin_en_q & (edge_hit | level_hit);

   // ----------------------------------------------------------------------
   // Pull device
   // ----------------------------------------------------------------------
   assign pull_enable    = pin_en_q & ~pull_dis_q;
   // Pull-up for falling polarity, pull-down for rising polarity.
   assign pull_up_select = pin_en_q & ~polarity_q;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // Every access completes in its first access cycle.
   assign pready      = 1'b1;
   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pwrite & addr_mapped(paddr);
   assign wr_csr      = wr_access & addr_hit(paddr, `EIPU_OFF_CSR);
   assign wr_stat     = wr_access & addr_hit(paddr, `EIPU_OFF_STAT);
   assign wr_mask     = wr_access & addr_hit(paddr, `EIPU_OFF_MASK);

   // Only a one in the acknowledge position requests a clear.
   assign ack_req     = wr_csr & pwdata[`EIPU_CSR_ACK];

   // In level mode the held active level keeps setting the flag, which by
   // priority defeats the acknowledge; this marks that refusal.
   assign ack_blocked = ack_req & pin_event & level_hit;

   // ----------------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pull_dis_q <= 1'b0;
         polarity_q <= 1'b0;
         pin_en_q   <= 1'b0;
         irq_en_q   <= 1'b0;
         mode_q     <= 1'b0;
      end else if (wr_csr) begin
         pull_dis_q <= pwdata[`EIPU_CSR_PULL_DIS];
         polarity_q <= pwdata[`EIPU_CSR_POLARITY];
         pin_en_q   <= pwdata[`EIPU_CSR_PIN_EN];
         irq_en_q   <= pwdata[`EIPU_CSR_IRQ_EN];
         mode_q     <= pwdata[`EIPU_CSR_MODE];
      end
   end

   // ----------------------------------------------------------------------
   // Event flag
   // ----------------------------------------------------------------------
   // Software cannot write the flag itself; only acknowledge clears it.
   always @* begin
      flag_d = flag_q;
      if (ack_req) begin
         flag_d = 1'b0;
      end
      if (pin_event) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Polling remains possible with the enable low.
   assign cpu_irq_req = irq_en_q & flag_q;

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------
   assign evt_set = {ack_blocked, pin_event};
   assign evt_clr = wr_stat ? pwdata[`EIPU_EVT_W-1:0] : {`EIPU_EVT_W{1'b0}};

   always @* begin
      stat_d = sticky_next(stat_q, evt_set, evt_clr);
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= `EIPU_STAT_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_q <= `EIPU_MASK_RESET;
      end else if (wr_mask) begin
         mask_q <= pwdata[`EIPU_EVT_W-1:0];
      end
   end

   assign irq = |(stat_q & mask_q);

   // ----------------------------------------------------------------------
   // Read data and error response
   // ----------------------------------------------------------------------
   // Read data is captured in the setup cycle so the bus sees a flip-flop;
   // the trade is that it reflects state one edge before the access edge.
   always @* begin
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      if (setup_phase) begin
         prdata_d  = 32'h0000_0000;
         pslverr_d = ~addr_mapped(paddr);
         if (!pwrite) begin
            if (addr_hit(paddr, `EIPU_OFF_CSR)) begin
               prdata_d[`EIPU_CSR_RSVD7]    = 1'b0;
               prdata_d[`EIPU_CSR_PULL_DIS] = pull_dis_q;
               prdata_d[`EIPU_CSR_POLARITY] = polarity_q;
               prdata_d[`EIPU_CSR_PIN_EN]   = pin_en_q;
               prdata_d[`EIPU_CSR_FLAG]     = flag_q;
               prdata_d[`EIPU_CSR_ACK]      = 1'b0;
               prdata_d[`EIPU_CSR_IRQ_EN]   = irq_en_q;
               prdata_d[`EIPU_CSR_MODE]     = mode_q;
            end else if (addr_hit(paddr, `EIPU_OFF_STAT)) begin
               prdata_d[`EIPU_EVT_W-1:0] = stat_q;
            end else if (addr_hit(paddr, `EIPU_OFF_MASK)) begin
               prdata_d[`EIPU_EVT_W-1:0] = mask_q;
            end
         end
      end else if (psel & penable) begin
         pslverr_d = pslverr_q;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & psel & penable;

endmodule

// ===== verif/eipu_src.sv
`timescale 1ns/1ps

module eipu_src (
   input  wire logic clk,
   input  wire logic drv,
   input  wire logic lvl,
   input  wire logic pull_enable,
   input  wire logic pull_up_select,
   output logic      irq_pin
);
   logic float_q = 1'b0;

   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // A released pin with no pull wanders, so nothing may rely on its last value.
   always_comb irq_pin = drv ? lvl : (pull_enable ? pull_up_select : float_q);
endmodule

// ===== verif/eipu_chk_sva.sv
`timescale 1ns/1ps

module eipu_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_pin,
   input wire logic        pull_enable,
   input wire logic        pull_up_select,
   input wire logic        cpu_irq_req,
   input wire logic        irq
);
   logic [6:0] c_q;
   logic [1:0] m_q;
   wire        wr_acc = psel && penable && pwrite;
   wire        csr_wr = wr_acc && paddr[11:2] == 10'h000;
   wire        ack_w  = csr_wr && pwdata[2];
   wire        ok     = c_q[5] && c_q[4] && c_q[1];

   // ---------------------------------------------------------------
   // Shadow of the control bits, so the outputs are judged from the bus.
   // ---------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         c_q <= 7'h00;
         m_q <= 2'h0;
      end else if (csr_wr) begin
         c_q <= pwdata[6:0];
      end else if (wr_acc && paddr[11:2] == 10'h002) begin
         m_q <= pwdata[1:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_pull_en; pull_enable == (c_q[4] && !c_q[6]); endproperty
   a_pull_en: assert property (p_pull_en) else $error("pull enable wrong");
   property p_pull_up; pull_up_select == (c_q[4] && !c_q[5]); endproperty
   a_pull_up: assert property (p_pull_up) else $error("pull sense wrong");
   property p_rd; psel && penable && !pwrite && paddr[11:2] == 10'h000 |-> prdata[31:7] == 25'h0
      && !prdata[2] && prdata[6:4] == c_q[6:4] && prdata[1:0] == c_q[1:0]; endproperty
   a_rd: assert property (p_rd) else $error("control read wrong");
   property p_edge; $rose(irq_pin) && ok ##1 (irq_pin && ok) [*2] ##0 !csr_wr |=> cpu_irq_req; endproperty
   a_edge: assert property (p_edge) else $error("edge missed");
   property p_held; (irq_pin == c_q[5] && c_q[4] && c_q[0] && !csr_wr) [*2] ##1
      (irq_pin == c_q[5] && ack_w && pwdata[1]) |=> cpu_irq_req; endproperty
   a_held: assert property (p_held) else $error("held level cleared");
   property p_ack; (irq_pin != c_q[5] && !csr_wr) [*2] ##1 (irq_pin != c_q[5] && ack_w) |=> !cpu_irq_req;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge ignored");
   property p_nopin; ack_w && !c_q[4] && !pwdata[4] |=> !cpu_irq_req; endproperty
   a_nopin: assert property (p_nopin) else $error("disabled pin event");
   property p_irq; irq |-> m_q != 2'h0; endproperty
   a_irq: assert property (p_irq) else $error("masked interrupt");

   c_ack: cover property (ack_w && cpu_irq_req);
   c_irq: cover property (irq);
   c_err: cover property (pslverr);
endmodule

bind eipu_top eipu_chk eipu_chk_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_pin(irq_pin), .pull_enable(pull_enable), .pull_up_select(pull_up_select),
   .cpu_irq_req(cpu_irq_req), .irq(irq));

// ===== verif/external_irq_pin_unit_test.sv
`timescale 1ns/1ps

module external_irq_pin_unit_test;
   logic        clk = 1'b0;
   logic        rst, psel, penable, pwrite, pready, pslverr, err, drv, lvl, irq_pin;
   logic        pull_enable, pull_up_select, cpu_irq_req, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, c;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          i, p;

   always #2 clk = ~clk;

   eipu_top eipu_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pin(irq_pin), .pull_enable(pull_enable), .pull_up_select(pull_up_select),
      .cpu_irq_req(cpu_irq_req), .irq(irq));
   eipu_src eipu_src_inst (.clk(clk), .drv(drv), .lvl(lvl), .pull_enable(pull_enable),
      .pull_up_select(pull_up_select), .irq_pin(irq_pin));

   // ---------------------------------------------------------------
   // Bus and pin tasks, each entered just after a rising edge.
   // ---------------------------------------------------------------
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         summarize();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   // The synchroniser needs about three cycles; five leave margin.
   task pin(input logic d, input logic l);
      drv <= d;
      lvl <= l;
      repeat (5) @(posedge clk);
   endtask

   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      drv = 1'b1;
      lvl = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      chk({pull_enable, pull_up_select, cpu_irq_req, irq}, 32'h0);
      for (i = 0; i < 8; i++) begin
         wr(12'h000, i << 4);
         chk({pull_enable, pull_up_select}, {i[0] & ~i[2], i[0] & ~i[1]});
      end
      wr(12'h000, 32'hFF);
      rd(12'h000, 32'h73);
      for (p = 0; p < 2; p++) begin
         c = 32'h12 | (p << 5);
         wr(12'h000, c);
         pin(1'b0, 1'b0);
         wr(12'h000, c | 32'hC);
         rd(12'h000, c);
         pin(1'b1, p[0]);
         rd(12'h000, c | 32'h8);
         chk(cpu_irq_req, 32'h1);
         wr(12'h000, c);
         rd(12'h000, c | 32'h8);
         wr(12'h000, c | 32'h4);
         rd(12'h000, c);
         pin(1'b0, 1'b0);
         rd(12'h000, c);
      end
      chk(irq, 32'h0);
      wr(12'h008, 32'h1);
      chk(irq, 32'h1);
      wr(12'h000, 32'h33);
      pin(1'b1, 1'b1);
      wr(12'h000, 32'h37);
      rd(12'h000, 32'h3B);
      rd(12'h004, 32'h3);
      pin(1'b0, 1'b0);
      wr(12'h000, 32'h37);
      rd(12'h000, 32'h33);
      chk(cpu_irq_req, 32'h0);
      wr(12'h004, 32'h3);
      rd(12'h004, 32'h0);
      chk(irq, 32'h0);
      wr(12'h000, 32'h20);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
      rd(12'h000, 32'h20);
      wr(12'h000, 32'h24);
      rd(12'h000, 32'h20);
      wr(12'h000, 32'h30);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
      rd(12'h000, 32'h38);
      chk(cpu_irq_req, 32'h0);
      wr(12'h00C, 32'hFFFFFFFF);
      chk(err, 32'h1);
      rd(12'h00C, 32'h0);
      rd(12'h000, 32'h38);
      chk(err, 32'h0);
      summarize();
   end
endmodule
